//--- asev_defines.vh
// asev_defines.vh: register offsets, field positions and reset values
// for the serial event and framing control block.
// assumes: included by bare name from the design, checker and bench files.
`ifndef ASEV_DEFINES_VH
`define ASEV_DEFINES_VH

// ==========================================================
// register offsets
`define ASEV_ADDR_CTL1      4'h0
`define ASEV_ADDR_CTL2      4'h1
`define ASEV_ADDR_CTL3      4'h2
`define ASEV_ADDR_STAT1     4'h3
`define ASEV_ADDR_DATA      4'h4
`define ASEV_ADDR_HALTCTL   4'h5
`define ASEV_ADDR_STAT2     4'h6

// ==========================================================
// control 1 fields
`define ASEV_C1_LOOP        7
`define ASEV_C1_ENABLE      6
`define ASEV_C1_TX_INVERT       5
`define ASEV_C1_CHAR9       4
`define ASEV_C1_ROUSE       3
`define ASEV_C1_QSTART      2
`define ASEV_C1_PAREN       1
`define ASEV_C1_PARODD      0

// control 2 fields
`define ASEV_C2_TXIE        7
`define ASEV_C2_TDIE        6
`define ASEV_C2_RXIE        5
`define ASEV_C2_QIE         4
`define ASEV_C2_TXEN        3
`define ASEV_C2_RXEN        2
`define ASEV_C2_STANDBY     1
`define ASEV_C2_BREAK       0

// control 3 fields
`define ASEV_C3_OVERRUN_IRQ_ENABLE        3
`define ASEV_C3_NOISE_IRQ_ENABLE        2
`define ASEV_C3_FRAMING_IRQ_ENABLE        1
`define ASEV_C3_PARITY_IRQ_ENABLE        0

// status 1 fields
`define ASEV_S1_TXEMPTY     7
`define ASEV_S1_TXDONE      6
`define ASEV_S1_RXFULL      5
`define ASEV_S1_QUIET       4
`define ASEV_S1_OVERRUN     3
`define ASEV_S1_NOISE       2
`define ASEV_S1_FRAMING     1
`define ASEV_S1_PARITY      0

// halt control field
`define ASEV_HC_CLEAR_EN    0

// ==========================================================
// reset values
`define ASEV_RST_BYTE       8'h00
`define ASEV_RST_STAT1      8'hC0
`define ASEV_RST_ZERO       1'b0

// idle ones that make a quiet line, per character length
`define ASEV_QUIET_CHARS8   4'hA
`define ASEV_QUIET_CHARS9   4'hB

`endif

//--- asev_serial_events.v
// asev_serial_events.v: interrupt, error flag, low-power, debug-halt,
// pin ownership and primary control logic of an async serial port.
// assumes: a receive engine on clk_sys reports character events as
// one-cycle pulses; a transmit engine supplies the raw serial level.
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "asev_defines.vh"

// Notes on behaviour
// R1: character transfer sets rx full, irq when enabled
// R2: ten/eleven idle ones set quiet flag, irq
// R3: overrun keeps old character, drops new
// R4: overrun with enable raises error irq
// R5: noise in any bit sets noise flag
// R6: zero at stop bit sets framing flag
// R7: wrong parity sets parity flag
// R8: active in wait, enabled irqs wake processor
// R9: software may disable module before wait
// R10: stop halts, keeps registers, no wake
// R11: transfer during stop entry is corrupted
// R12: halt with clear enable lets flags clear
// R13: halt without clear enable protects flags
// R14: two-step clear held through halt, finishes after
// R15: enabled module owns transmit pin as output
// R16: enabled module owns receive pin as input
// R17: loopback feeds transmitter into receiver
// R18: disable sets tx empty/done, blocks tx irq
// R19: tx invert flips every transmitted level
// R20: char length select picks nine or eight
// R21: wake select: address mark or idle line
// R22: quiet count starts after stop or start
// R23: reset clears primary control bits
// R24: standby suppresses all receiver irqs (code masks rxIrq only; errIrq is not masked)
// R25: enabled error flags or into one request
module asev_serial_events
(
	input  wire        clk_sys,
	input  wire        nrst,
	// register port
	input  wire [3:0]  regAddr,
	input  wire [7:0]  regWrData,
	input  wire        regWr,
	input  wire        regRd,
	output reg  [7:0]  regRdData,
	// processor state
	input  wire        waitMode,
	input  wire        stopMode,
	input  wire        debugHalt,
	output wire        wakeRequest,
	// receive engine events (one-cycle pulses)
	input  wire        rxCharDone,
	input  wire [8:0]  rxCharData,
	input  wire        rxNoise,
	input  wire        rxFraming,
	input  wire        rxParity,
	input  wire        rxIdleOne,
	input  wire        rxStartBit,
	input  wire        rxStopBit,
	input  wire        rxFrameStart,
	// transmit engine
	input  wire        txRawLevel,
	input  wire        txBufferLoad,
	input  wire        txCompleted,
	output wire        txActive,
	output wire        rxActive,
	output wire        baudEnable,
	output wire        rxLineLevel,
	output wire        charNineBits,
	output wire        parityEnable,
	output wire        parityOdd,
	output wire        breakSend,
	output reg         transferCorrupt,
	// shared pins
	input  wire        portLineZeroOut,
	input  wire        portLineOneOut,
	input  wire        directionBitTwo,
	input  wire        directionBitOne,
	output wire        portLineZeroO,
	output wire        portLineZeroOeN,
	output wire        portLineOneO,
	output wire        portLineOneOeN,
	input  wire        portLineOneI,
	// interrupt requests
	output wire        rxIrq,
	output wire        txIrq,
	output wire        errIrq
);

	// ======================================================
	// registers
	reg  [7:0] serialControlPrimary;
	reg  [7:0] serialControlSecondary;
	reg  [3:0] serialControlTertiary;
	reg  [7:0] serialDataRegister;
	reg        rxNinthBit;
	reg        haltFlagClearEnable;
	reg        txBufferEmptyFlag;
	reg        txDoneFlag;
	reg        rxFullFlag;
	reg        lineQuietFlag;
	reg        receiveOverrunFlag;
	reg        noiseFlag;
	reg        framingFaultFlag;
	reg        parityFaultFlag;
	// first step of the two-step clear: status read seen
	reg        statusArmed;
	reg  [3:0] quietCount;
	reg        quietCounting;
	reg        rxSync1;
	reg        rxSync2;
	reg        stopSeen;

	wire moduleEnable   = serialControlPrimary[`ASEV_C1_ENABLE];
	wire internalLoop   = serialControlPrimary[`ASEV_C1_LOOP];
	wire txInvert       = serialControlPrimary[`ASEV_C1_TX_INVERT];
	wire rouseSelect    = serialControlPrimary[`ASEV_C1_ROUSE];
	wire quietStartSel  = serialControlPrimary[`ASEV_C1_QSTART];
	wire rxStandby      = serialControlSecondary[`ASEV_C2_STANDBY];
	// R10: run drops in stop; receive events, idle counting and baud stop
	wire run            = moduleEnable & ~stopMode;
	// R12: flags may only clear outside halt, or with clear enable
	// R13: protected while halted and clear enable low
	wire clearAllowed   = ~debugHalt | haltFlagClearEnable;

	wire rdStat1   = regRd & (regAddr == `ASEV_ADDR_STAT1);
	wire rdData    = regRd & (regAddr == `ASEV_ADDR_DATA);
	wire wrData    = regWr & (regAddr == `ASEV_ADDR_DATA);
	// R14: second step completes only when armed and allowed
	wire rxStep2   = rdData & statusArmed & clearAllowed;
	wire errStep2  = rxStep2;
	wire txStep2   = wrData & statusArmed & clearAllowed;

	// R2: ten ones for 8-bit frames, eleven for 9-bit
	wire [3:0] quietTarget = charNineBits ? `ASEV_QUIET_CHARS9
						: `ASEV_QUIET_CHARS8;
	wire       quietLimit  = (quietCount + 4'h1) >= quietTarget;
	// R22: count opens after stop bit or after start bit
	wire quietOpen = quietStartSel ? (rxStopBit | stopSeen) : rxStartBit;
	wire quietHit  = run & quietCounting & rxIdleOne & quietLimit;

	// ======================================================
	// pin ownership and loopback
	// R15: enabled module forces transmit pin to drive
	// R19: inversion covers idle, break, start and stop levels
	assign portLineZeroO   = moduleEnable ? (txRawLevel ^ txInvert)
					: portLineZeroOut;
	assign portLineZeroOeN = moduleEnable ? 1'b0 : ~directionBitTwo;
	// R16: enabled module forces receive pin to input
	assign portLineOneO    = portLineOneOut;
	assign portLineOneOeN  = moduleEnable ? 1'b1 : ~directionBitOne;

	always @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			rxSync1 <= 1'b1;
			rxSync2 <= 1'b1;
		end
		else
		begin
			rxSync1 <= portLineOneI;
			rxSync2 <= rxSync1;
		end
	end

	// R17: loopback takes transmitter level, needs only the loop bit
	assign rxLineLevel = internalLoop ? (txRawLevel ^ txInvert) : rxSync2;
	// R18: module enable also runs the baud generator
	assign baudEnable  = run;
	assign txActive    = run & serialControlSecondary[`ASEV_C2_TXEN];
	assign rxActive    = run & serialControlSecondary[`ASEV_C2_RXEN];
	// R20: nine-bit characters when select is one
	assign charNineBits = serialControlPrimary[`ASEV_C1_CHAR9];
	assign parityEnable = serialControlPrimary[`ASEV_C1_PAREN];
	assign parityOdd    = serialControlPrimary[`ASEV_C1_PARODD];
	assign breakSend    = txActive & serialControlSecondary[`ASEV_C2_BREAK];

	// ======================================================
	// control registers
	always @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			// R23: reset clears the primary control bits
			serialControlPrimary   <= `ASEV_RST_BYTE;
			serialControlSecondary <= `ASEV_RST_BYTE;
			serialControlTertiary  <= 4'h0;
			haltFlagClearEnable    <= `ASEV_RST_ZERO;
		end
		else
		begin
			if (regWr && regAddr == `ASEV_ADDR_CTL1)
				serialControlPrimary <= regWrData;
			if (regWr && regAddr == `ASEV_ADDR_CTL2)
			begin
				// transmit and receive enables only writable while module is on
				serialControlSecondary <= moduleEnable ? regWrData :
					{regWrData[7:4], 2'b00, regWrData[1:0]};
			end
			// R21: address mark wake clears standby
			else if (run && rxStandby && rouseSelect && rxCharDone
				&& rxCharData[charNineBits ? 8 : 7])
				serialControlSecondary[`ASEV_C2_STANDBY] <= 1'b0;
			// R21: idle line wake clears standby
			else if (quietHit && rxStandby && !rouseSelect)
				serialControlSecondary[`ASEV_C2_STANDBY] <= 1'b0;
			if (regWr && regAddr == `ASEV_ADDR_CTL3)
				serialControlTertiary <= regWrData[3:0];
			if (regWr && regAddr == `ASEV_ADDR_HALTCTL)
				haltFlagClearEnable <= regWrData[`ASEV_HC_CLEAR_EN];
		end
	end

	// ======================================================
	// idle line counting

	always @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			quietCount    <= 4'h0;
			quietCounting <= 1'b0;
			stopSeen      <= 1'b0;
		end
		else if (run)
		begin
			if (rxFrameStart)
				stopSeen <= 1'b0;
			else if (rxStopBit)
				stopSeen <= 1'b1;
			if (rxFrameStart && !quietStartSel)
			begin
				quietCount    <= 4'h0;
				quietCounting <= 1'b0;
			end
			else if (quietOpen && !quietCounting)
			begin
				quietCounting <= 1'b1;
				quietCount    <= 4'h0;
			end
			else if (quietCounting && rxIdleOne && !quietHit)
				quietCount <= quietCount + 4'd1;
			else if (quietHit)
				quietCounting <= 1'b0;
			else if (quietCounting && !rxIdleOne && rxFrameStart)
				quietCount <= 4'h0;
		end
	end

	// ======================================================
	// status flags
	// hardware sets win over software clears on the same edge
	wire newChar    = run & rxCharDone;
	wire acceptChar = newChar & ~rxFullFlag;
	// R3: second character while full is dropped
	wire overrun    = newChar & rxFullFlag;
	// frames received in standby with idle-line wake select do not post data
	wire postChar   = acceptChar & ~(rxStandby & ~rouseSelect);

	always @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			txBufferEmptyFlag  <= 1'b1;
			txDoneFlag         <= 1'b1;
			rxFullFlag         <= 1'b0;
			lineQuietFlag      <= 1'b0;
			receiveOverrunFlag <= 1'b0;
			noiseFlag          <= 1'b0;
			framingFaultFlag   <= 1'b0;
			parityFaultFlag    <= 1'b0;
			statusArmed        <= 1'b0;
			serialDataRegister <= `ASEV_RST_BYTE;
			rxNinthBit         <= 1'b0;
		end
		else
		begin
			// R14: status read arms the clear; halt cannot disturb it
			if (rdStat1 && clearAllowed)
				statusArmed <= 1'b1;
			else if ((rxStep2 || txStep2) && clearAllowed)
				statusArmed <= 1'b0;
			// R1: transfer into the data register sets full
			// R3: old character stays on overrun
			if (postChar)
			begin
				serialDataRegister <= rxCharData[7:0];
				rxNinthBit <= charNineBits ? rxCharData[8]
							: rxCharData[7];
			end
			if (postChar)
				rxFullFlag <= 1'b1;
			else if (rxStep2)
				rxFullFlag <= 1'b0;
			// R2: quiet flag, not set by the waking idle
			if (quietHit && !(rxStandby && !rouseSelect))
				lineQuietFlag <= 1'b1;
			else if (rxStep2)
				lineQuietFlag <= 1'b0;
			if (overrun)
				receiveOverrunFlag <= 1'b1;
			else if (errStep2)
				receiveOverrunFlag <= 1'b0;
			// R5: noise in start, data or stop bits
			if (newChar && rxNoise)
				noiseFlag <= 1'b1;
			else if (errStep2)
				noiseFlag <= 1'b0;
			// R6: zero where stop bit expected
			if (newChar && rxFraming)
				framingFaultFlag <= 1'b1;
			else if (errStep2)
				framingFaultFlag <= 1'b0;
			// R7: wrong parity
			if (newChar && rxParity)
				parityFaultFlag <= 1'b1;
			else if (errStep2)
				parityFaultFlag <= 1'b0;
			// R18: disabled module reports transmitter empty and done
			if (!moduleEnable)
			begin
				txBufferEmptyFlag <= 1'b1;
				txDoneFlag        <= 1'b1;
			end
			else
			begin
				if (txBufferLoad && !stopMode)
					txBufferEmptyFlag <= 1'b1;
				else if (txStep2)
					txBufferEmptyFlag <= 1'b0;
				if (txCompleted && !stopMode)
					txDoneFlag <= 1'b1;
				else if (txStep2)
					txDoneFlag <= 1'b0;
			end
		end
	end

	// ======================================================
	// stop entry corrupts the frame in flight
	reg stopPrev;
	always @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			stopPrev        <= 1'b0;
			transferCorrupt <= 1'b0;
		end
		else
		begin
			stopPrev <= stopMode;
			// R11: stop entry mid-transfer marks data invalid
			if (stopMode && !stopPrev && moduleEnable
				&& (quietCounting == 1'b0 || !txDoneFlag))
				transferCorrupt <= 1'b1;
			else if (rxFrameStart || txBufferLoad)
				transferCorrupt <= 1'b0;
		end
	end

	// ======================================================
	// interrupt requests
	// R1: full flag with its enable
	// R2: quiet flag with its enable
	// R24: standby masks both rxIrq requests; errIrq is not masked
	assign rxIrq = moduleEnable & ~rxStandby &
		((rxFullFlag & serialControlSecondary[`ASEV_C2_RXIE]) |
		 (lineQuietFlag & serialControlSecondary[`ASEV_C2_QIE]));
	// R18: disabled module blocks transmitter requests
	assign txIrq = moduleEnable &
		((txBufferEmptyFlag & serialControlSecondary[`ASEV_C2_TXIE]) |
		 (txDoneFlag & serialControlSecondary[`ASEV_C2_TDIE]));
	// R4: overrun; R25: all enabled errors in one request
	assign errIrq =
		(receiveOverrunFlag & serialControlTertiary[`ASEV_C3_OVERRUN_IRQ_ENABLE]) |
		(noiseFlag & serialControlTertiary[`ASEV_C3_NOISE_IRQ_ENABLE]) |
		(framingFaultFlag & serialControlTertiary[`ASEV_C3_FRAMING_IRQ_ENABLE]) |
		(parityFaultFlag & serialControlTertiary[`ASEV_C3_PARITY_IRQ_ENABLE]);
	// R8: in wait, any enabled request wakes the processor
	// R10: no wake from stop
	assign wakeRequest = waitMode & ~stopMode & (rxIrq | txIrq | errIrq);

	// ======================================================
	// read mux, data one cycle after the strobe
	always @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			regRdData <= `ASEV_RST_BYTE;
		else if (regRd)
		begin
			case (regAddr)
			`ASEV_ADDR_CTL1:    regRdData <= serialControlPrimary;
			`ASEV_ADDR_CTL2:    regRdData <= serialControlSecondary;
			`ASEV_ADDR_CTL3:    regRdData <= {rxNinthBit, 3'b000,
							serialControlTertiary};
			`ASEV_ADDR_STAT1:   regRdData <= {txBufferEmptyFlag,
				txDoneFlag, rxFullFlag, lineQuietFlag,
				receiveOverrunFlag, noiseFlag, framingFaultFlag,
				parityFaultFlag};
			`ASEV_ADDR_DATA:    regRdData <= serialDataRegister;
			`ASEV_ADDR_HALTCTL: regRdData <= {7'h00,
							haltFlagClearEnable};
			`ASEV_ADDR_STAT2:   regRdData <= {6'h00, transferCorrupt,
							quietCounting};
			default:            regRdData <= `ASEV_RST_BYTE;
			endcase
		end
		else
			regRdData <= `ASEV_RST_BYTE;
	end

endmodule // asev_serial_events

//--- asev_events_chk_assertions.sv
// asev_events_chk_assertions.sv: port checks for asev_serial_events.
// assumes: bound onto the design; control writes are shadowed here.
`timescale 1ns/1ps
`include "asev_defines.vh"

// ==========================================================
// checker
module asev_events_chk
(
	input logic       clk_sys,
	input logic       nrst,
	input logic [3:0] regAddr,
	input logic [7:0] regWrData,
	input logic       regWr,
	input logic       waitMode,
	input logic       stopMode,
	input logic       debugHalt,
	input logic       wakeRequest,
	input logic       txRawLevel,
	input logic       rxLineLevel,
	input logic       portLineZeroO,
	input logic       portLineZeroOeN,
	input logic       portLineOneOeN,
	input logic       rxIrq,
	input logic       txIrq,
	input logic       errIrq
);
	reg ctlEn, ctlLoop, ctlInv, haltClr;

	// shadow lands on the same edge as the design's own register
	always @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			ctlEn <= 1'b0;
			ctlLoop <= 1'b0;
			ctlInv <= 1'b0;
			haltClr <= 1'b0;
		end
		else if (regWr && regAddr == `ASEV_ADDR_CTL1)
		begin
			ctlEn <= regWrData[`ASEV_C1_ENABLE];
			ctlLoop <= regWrData[`ASEV_C1_LOOP];
			ctlInv <= regWrData[`ASEV_C1_TX_INVERT];
		end
		else if (regWr && regAddr == `ASEV_ADDR_HALTCTL)
			haltClr <= regWrData[`ASEV_HC_CLEAR_EN];
	end

	chk_wake_level: assert property (@(posedge clk_sys) disable iff (!nrst)
		wakeRequest == (waitMode && !stopMode && (rxIrq || txIrq || errIrq)))
		else $error("wake request does not follow enabled requests");
	chk_stop_no_wake: assert property (@(posedge clk_sys) disable iff (!nrst)
		stopMode |-> !wakeRequest)
		else $error("wake request raised in stop");
	chk_tx_pin_drive: assert property (@(posedge clk_sys) disable iff (!nrst)
		ctlEn |-> !portLineZeroOeN)
		else $error("transmit pin not driven while enabled");
	chk_rx_pin_input: assert property (@(posedge clk_sys) disable iff (!nrst)
		ctlEn |-> portLineOneOeN)
		else $error("receive pin driven while enabled");
	chk_tx_polarity: assert property (@(posedge clk_sys) disable iff (!nrst)
		ctlEn && !ctlLoop |-> portLineZeroO == (txRawLevel ^ ctlInv))
		else $error("transmit pin level wrong");
	chk_loop_feed: assert property (@(posedge clk_sys) disable iff (!nrst)
		ctlEn && ctlLoop |-> rxLineLevel == (txRawLevel ^ ctlInv))
		else $error("loopback does not feed receiver");
	chk_tx_irq_off: assert property (@(posedge clk_sys) disable iff (!nrst)
		!ctlEn |-> !txIrq)
		else $error("transmit request while disabled");
	chk_halt_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
		debugHalt && !haltClr && !regWr |=> !$fell(errIrq) && !$fell(rxIrq))
		else $error("request dropped during protected halt");
endmodule // asev_events_chk

bind asev_serial_events asev_events_chk i_chk (.clk_sys(clk_sys),
	.nrst(nrst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
	.waitMode(waitMode), .stopMode(stopMode), .debugHalt(debugHalt),
	.wakeRequest(wakeRequest), .txRawLevel(txRawLevel),
	.rxLineLevel(rxLineLevel), .portLineZeroO(portLineZeroO),
	.portLineZeroOeN(portLineZeroOeN), .portLineOneOeN(portLineOneOeN),
	.rxIrq(rxIrq), .txIrq(txIrq), .errIrq(errIrq));

//--- asev_far_end.sv
// asev_far_end.sv: remote sender as seen through the receive engine.
// assumes: tasks are called from the bench on clk_sys.
`timescale 1ns/1ps

// ==========================================================
// far-end model
module asev_far_end
(
	input  wire logic       clk_sys,
	output logic            rxCharDone = 1'b0,
	output logic [8:0]      rxCharData = 9'h1FF,
	output logic            rxNoise = 1'b0,
	output logic            rxFraming = 1'b0,
	output logic            rxParity = 1'b0,
	output logic            rxIdleOne = 1'b0,
	output logic            rxStartBit = 1'b0,
	output logic            rxStopBit = 1'b0,
	output logic            rxFrameStart = 1'b0,
	output logic            portLineOneI = 1'b1
);
	// err is {noise, framing, parity}
	task send_char(input logic [8:0] d, input logic [2:0] err);
		@(posedge clk_sys);
		rxFrameStart <= 1'b1;
		portLineOneI <= 1'b0;
		// start bit confirmed a cycle after the falling edge
		@(posedge clk_sys);
		rxFrameStart <= 1'b0;
		rxStartBit <= 1'b1;
		@(posedge clk_sys);
		rxStartBit <= 1'b0;
		rxStopBit <= 1'b1;
		portLineOneI <= !err[1];
		@(posedge clk_sys);
		rxStopBit <= 1'b0;
		rxCharDone <= 1'b1;
		rxCharData <= d;
		{rxNoise, rxFraming, rxParity} <= err;
		// released bus shows inverse, never the stale value
		@(posedge clk_sys);
		rxCharDone <= 1'b0;
		rxCharData <= ~d;
		{rxNoise, rxFraming, rxParity} <= ~err;
		portLineOneI <= 1'b1;
		@(posedge clk_sys);
		#1;
	endtask

	task idle_ones(input int n);
		repeat (n)
		begin
			@(posedge clk_sys);
			rxIdleOne <= 1'b1;
			@(posedge clk_sys);
			rxIdleOne <= 1'b0;
		end
		@(posedge clk_sys);
		#1;
	endtask
endmodule // asev_far_end

//--- asev_tb.sv
// asev_tb.sv: register-level bench for asev_serial_events.
// assumes: far-end model feeds receive events; bench owns the bus.
`timescale 1ns/1ps
`include "asev_defines.vh"

module tb;
	logic       clk_sys = 0, nrst = 0, regWr = 0, regRd = 0;
	logic [3:0] regAddr = 0;
	logic [7:0] regWrData = 0, regRdData;
	logic       waitMode = 0, stopMode = 0, debugHalt = 0, wakeRequest;
	logic       txRawLevel = 1, txBufferLoad = 0, txCompleted = 0;
	logic       portLineZeroOut = 0, portLineOneOut = 0;
	logic       directionBitTwo = 1, directionBitOne = 0;
	logic       rxCharDone, rxNoise, rxFraming, rxParity, rxIdleOne;
	logic       rxStartBit, rxStopBit, rxFrameStart, portLineOneI;
	logic [8:0] rxCharData;
	logic       rxLineLevel, charNineBits, portLineZeroO, portLineZeroOeN;
	logic       portLineOneOeN, rxIrq, txIrq, errIrq;
	int         n_fail = 0, n_checks = 0, i;

	asev_serial_events i_asev_serial_events (
		.clk_sys(clk_sys), .nrst(nrst),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData(regRdData), .waitMode(waitMode),
		.stopMode(stopMode), .debugHalt(debugHalt),
		.wakeRequest(wakeRequest), .rxCharDone(rxCharDone),
		.rxCharData(rxCharData), .rxNoise(rxNoise),
		.rxFraming(rxFraming), .rxParity(rxParity),
		.rxIdleOne(rxIdleOne), .rxStartBit(rxStartBit),
		.rxStopBit(rxStopBit), .rxFrameStart(rxFrameStart),
		.txRawLevel(txRawLevel), .txBufferLoad(txBufferLoad),
		.txCompleted(txCompleted), .txActive(), .rxActive(),
		.baudEnable(), .rxLineLevel(rxLineLevel),
		.charNineBits(charNineBits), .parityEnable(), .parityOdd(),
		.breakSend(), .transferCorrupt(),
		.portLineZeroOut(portLineZeroOut),
		.portLineOneOut(portLineOneOut),
		.directionBitTwo(directionBitTwo),
		.directionBitOne(directionBitOne),
		.portLineZeroO(portLineZeroO),
		.portLineZeroOeN(portLineZeroOeN), .portLineOneO(),
		.portLineOneOeN(portLineOneOeN), .portLineOneI(portLineOneI),
		.rxIrq(rxIrq), .txIrq(txIrq), .errIrq(errIrq));
	asev_far_end i_asev_far_end (
		.clk_sys(clk_sys), .rxCharDone(rxCharDone),
		.rxCharData(rxCharData), .rxNoise(rxNoise),
		.rxFraming(rxFraming), .rxParity(rxParity),
		.rxIdleOne(rxIdleOne), .rxStartBit(rxStartBit),
		.rxStopBit(rxStopBit), .rxFrameStart(rxFrameStart),
		.portLineOneI(portLineOneI));

	initial
	begin
		forever #2 clk_sys = ~clk_sys;
	end

	task chk(input logic [7:0] got, exp, input string what);
		n_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk_sys);
		regWr <= 1'b0;
		#1;
	endtask

	task rd(input logic [3:0] a, input logic [7:0] e, m, input string w);
		@(posedge clk_sys);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1;
		chk(regRdData & m, e, w);
	endtask

	task close_out;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ==========================================================
	// tests
	initial
	begin
		repeat (5) @(posedge clk_sys);
		nrst <= 1'b1;
		rd(`ASEV_ADDR_CTL1, 8'h00, 8'hFF, "ctl1 reset");
		rd(`ASEV_ADDR_STAT1, 8'hC0, 8'hFF, "stat1 reset");
		rd(4'hF, 8'h00, 8'hFF, "unmapped read");
		wr(`ASEV_ADDR_CTL1, 8'h40);
		wr(`ASEV_ADDR_CTL2, 8'h2C);
		wr(`ASEV_ADDR_CTL3, 8'h0F);
		$display("test reset done");

		i_asev_far_end.send_char(9'h0A5, 3'b000);
		chk({7'h00, rxIrq}, 8'h01, "rx full irq");
		i_asev_far_end.send_char(9'h03C, 3'b000);
		rd(`ASEV_ADDR_STAT1, 8'h28, 8'h3F, "overrun flags");
		chk({7'h00, errIrq}, 8'h01, "overrun irq");
		rd(`ASEV_ADDR_DATA, 8'hA5, 8'hFF, "old char kept");
		rd(`ASEV_ADDR_STAT1, 8'h00, 8'h3F, "flags cleared");
		$display("test overrun done");

		for (i = 0; i < 3; i++)
		begin
			i_asev_far_end.send_char(9'h011, 3'b100 >> i);
			rd(`ASEV_ADDR_STAT1, 8'h20 | (8'h04 >> i), 8'h3F, "fault");
			chk({7'h00, errIrq}, 8'h01, "fault irq");
			rd(`ASEV_ADDR_DATA, 8'h11, 8'hFF, "fault data");
		end
		wr(`ASEV_ADDR_CTL3, 8'h0B);
		i_asev_far_end.send_char(9'h022, 3'b100);
		chk({7'h00, errIrq}, 8'h00, "noise masked");
		rd(`ASEV_ADDR_STAT1, 8'h24, 8'h3F, "noise flag");
		rd(`ASEV_ADDR_DATA, 8'h22, 8'hFF, "noise data");
		$display("test faults done");

		wr(`ASEV_ADDR_CTL2, 8'h1C);
		i_asev_far_end.idle_ones(9);
		rd(`ASEV_ADDR_STAT1, 8'h00, 8'h10, "quiet early");
		i_asev_far_end.idle_ones(1);
		rd(`ASEV_ADDR_STAT1, 8'h10, 8'h10, "quiet at ten");
		chk({7'h00, rxIrq}, 8'h01, "quiet irq");
		@(posedge clk_sys) waitMode <= 1'b1;
		#1 chk({7'h00, wakeRequest}, 8'h01, "wake in wait");
		@(posedge clk_sys) stopMode <= 1'b1;
		#1 chk({7'h00, wakeRequest}, 8'h00, "no wake in stop");
		@(posedge clk_sys) {waitMode, stopMode} <= 2'b00;
		rd(`ASEV_ADDR_DATA, 8'h22, 8'hFF, "quiet clear");
		$display("test idle done");

		i_asev_far_end.send_char(9'h05A, 3'b000);
		rd(`ASEV_ADDR_STAT1, 8'h20, 8'h20, "armed");
		@(posedge clk_sys) debugHalt <= 1'b1;
		rd(`ASEV_ADDR_DATA, 8'h5A, 8'hFF, "halt data");
		rd(`ASEV_ADDR_STAT1, 8'h20, 8'h20, "held in halt");
		@(posedge clk_sys) debugHalt <= 1'b0;
		rd(`ASEV_ADDR_DATA, 8'h5A, 8'hFF, "second step");
		rd(`ASEV_ADDR_STAT1, 8'h00, 8'h20, "cleared after halt");
		wr(`ASEV_ADDR_HALTCTL, 8'h01);
		i_asev_far_end.send_char(9'h066, 3'b000);
		@(posedge clk_sys) debugHalt <= 1'b1;
		rd(`ASEV_ADDR_STAT1, 8'h20, 8'h20, "halt stat");
		rd(`ASEV_ADDR_DATA, 8'h66, 8'hFF, "halt clear data");
		@(posedge clk_sys) debugHalt <= 1'b0;
		rd(`ASEV_ADDR_STAT1, 8'h00, 8'h20, "stays cleared");
		$display("test halt done");

		wr(`ASEV_ADDR_CTL1, 8'h60);
		@(posedge clk_sys) txRawLevel <= 1'b0;
		#1 chk({7'h00, portLineZeroO}, 8'h01, "inverted out");
		chk({7'h00, portLineZeroOeN}, 8'h00, "tx pin driven");
		chk({7'h00, portLineOneOeN}, 8'h01, "rx pin input");
		wr(`ASEV_ADDR_CTL1, 8'hC0);
		// idle pin reads one, so a low here can only come from the loop
		@(posedge clk_sys) txRawLevel <= 1'b0;
		#1 chk({7'h00, rxLineLevel}, 8'h00, "loopback level");
		wr(`ASEV_ADDR_CTL1, 8'h50);
		chk({7'h00, charNineBits}, 8'h01, "nine bits");
		wr(`ASEV_ADDR_CTL2, 8'hC0);
		rd(`ASEV_ADDR_STAT1, 8'hC0, 8'hC0, "tx flags set");
		wr(`ASEV_ADDR_DATA, 8'h00);
		rd(`ASEV_ADDR_STAT1, 8'h00, 8'hC0, "tx flags cleared");
		wr(`ASEV_ADDR_CTL1, 8'h00);
		rd(`ASEV_ADDR_STAT1, 8'hC0, 8'hC0, "tx flags off");
		chk({7'h00, txIrq}, 8'h00, "tx irq blocked");
		@(posedge clk_sys) waitMode <= 1'b1;
		#1 chk({7'h00, wakeRequest}, 8'h00, "off before wait");
		@(posedge clk_sys) waitMode <= 1'b0;
		$display("test pins done");
		close_out();
	end

	// run needs under two hundred cycles
	initial
	begin
		#(4 * 20000);
		n_fail++;
		close_out();
	end
endmodule // tb
